//--- src/dmd_top.sv
/*
 * Internal data-space decoder and storage of an 8051-style core.
 * Assumes one core request per cycle; read data lands next edge.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dmd_cfg.svh"

module dmd_top
	import dmd_pkg::*;
(
	input wire logic mclk, // system clock, 50 MHz
	input wire logic nrst, // async reset, active low
	input wire dmd_req_t req, // data-space request
	input wire logic movx_wr, // movx write strobe
	input wire logic [15:0] paddr, // program/movx address
	input wire logic is_8k, // variant strap, 8 kB when high
	output logic [7:0] rdata_ff, // byte or bit (bit 0) read
	output logic rvalid_ff, // read data valid pulse
	output logic [1:0] bank_ff, // active register bank
	output logic [7:0] stack_ptr_ff, // stack_top_pointer
	output logic sfr_ext_ff, // access went to other SPECIAL_FUNCTION_REGISTER
	output logic flash_wr_ff, // movx write to flash pulse
	output logic xdata_wr_ff, // movx write to ext data
	output logic prog_ok_ff // program address backed and not reserved
);
	logic [7:0] ram_ff [`DMD_RAM_DEPTH];
	logic [7:0] program_status_word_ff;
	logic [7:0] program_store_control_ff, eff_addr;
	logic [2:0] bit_pos;
	logic is_sfr, backed, reserved;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// bank register address: bank times eight plus register number
	function automatic logic [7:0] reg_addr(input logic [1:0] b,
		input logic [2:0] r);
		reg_addr = {3'h0, b, r};
	endfunction

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	always_comb
	begin
		bit_pos = 3'h0;
		is_sfr = 1'b0;
		if (req.bit_op)
		begin
			bit_pos = req.addr[2:0];
			if (req.addr[`DMD_UPPER_BIT])
			begin
				eff_addr = {req.addr[7:3], 3'h0};
				is_sfr = 1'b1;
			end
			else
				eff_addr = {`DMD_BITRAM_BYTE, req.addr[6:3]};
		end
		else if (req.reg_op)
			eff_addr = reg_addr(bank_ff, req.reg_num);
		else if (req.indirect)
			// pointer is R0/R1 of active bank; same cell below 0x80
			eff_addr = ram_ff[reg_addr(bank_ff,
				{2'h0, req.reg_num[0]})];
		else
		begin
			eff_addr = req.addr;
			is_sfr = req.addr[`DMD_UPPER_BIT];
		end
	end

	assign bank_ff = {program_status_word_ff[`DMD_RS_HI],
		program_status_word_ff[`DMD_RS_LO]};

	// ----------------------------------------------------------------
	// status word, program store control
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			program_status_word_ff <= `DMD_PSW_RESET;
			program_store_control_ff <= `DMD_PROGRAM_STORE_CONTROL_RESET;
		end
		else if (req.valid && req.wr && is_sfr && !req.push)
		begin
			if (req.bit_op)
			begin
				if (eff_addr == `DMD_SFR_PSW)
					program_status_word_ff[bit_pos] <= req.wdata[0];
			end
			else if (eff_addr == `DMD_SFR_PSW)
				program_status_word_ff <= req.wdata;
			else if (eff_addr == `DMD_SFR_PROGRAM_STORE_CONTROL)
				program_store_control_ff <= req.wdata;
		end
	end

	// ----------------------------------------------------------------
	// stack pointer
	// ----------------------------------------------------------------
	// push takes priority over a direct write in the same cycle
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			stack_ptr_ff <= `DMD_SP_RESET;
		else if (req.valid && req.push)
			stack_ptr_ff <= stack_ptr_ff + 8'h01;
		else if (req.valid && req.wr && is_sfr && !req.bit_op &&
			eff_addr == `DMD_SFR_SP)
			stack_ptr_ff <= req.wdata;
	end

	// ----------------------------------------------------------------
	// data RAM
	// ----------------------------------------------------------------
	// stack wraps across the full 256 bytes, no bound check
	always_ff @(posedge mclk)
	begin
		if (req.valid && req.push)
			ram_ff[stack_ptr_ff + 8'h01] <= req.wdata;
		else if (req.valid && req.wr && !is_sfr)
		begin
			if (req.bit_op)
				ram_ff[eff_addr][bit_pos] <= req.wdata[0];
			else
				ram_ff[eff_addr] <= req.wdata;
		end
	end

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	// unoccupied SFRs read zero and are flagged external
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			rdata_ff <= 8'h00;
			rvalid_ff <= 1'b0;
			sfr_ext_ff <= 1'b0;
		end
		else
		begin
			rvalid_ff <= req.valid && !req.wr && !req.push;
			sfr_ext_ff <= req.valid && is_sfr &&
				eff_addr != `DMD_SFR_SP && eff_addr != `DMD_SFR_PSW &&
				eff_addr != `DMD_SFR_PROGRAM_STORE_CONTROL;
			if (!is_sfr)
				rdata_ff <= req.bit_op ?
					{7'h00, ram_ff[eff_addr][bit_pos]} :
					ram_ff[eff_addr];
			else if (eff_addr == `DMD_SFR_SP)
				rdata_ff <= req.bit_op ? 8'h00 : stack_ptr_ff;
			else if (eff_addr == `DMD_SFR_PSW)
				rdata_ff <= req.bit_op ?
					{7'h00, program_status_word_ff[bit_pos]} :
					program_status_word_ff;
			else if (eff_addr == `DMD_SFR_PROGRAM_STORE_CONTROL && !req.bit_op)
				rdata_ff <= program_store_control_ff;
			else
				rdata_ff <= 8'h00;
		end
	end

	// ----------------------------------------------------------------
	// program space and movx routing
	// ----------------------------------------------------------------
	dmd_prog_map u_prog_map (
		.paddr(paddr),
		.is_8k(is_8k),
		.backed(backed),
		.reserved(reserved)
	);

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			flash_wr_ff <= 1'b0;
			xdata_wr_ff <= 1'b0;
			prog_ok_ff <= 1'b0;
		end
		else
		begin
			flash_wr_ff <= movx_wr &&
				program_store_control_ff[`DMD_PSWE_BIT];
			xdata_wr_ff <= movx_wr &&
				!program_store_control_ff[`DMD_PSWE_BIT];
			prog_ok_ff <= backed && !reserved;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	property p_push_inc;
		@(posedge mclk) disable iff (!nrst)
		req.valid && req.push |=> stack_ptr_ff == $past(stack_ptr_ff) + 8'h01;
	endproperty
	a_push_inc: assert property (p_push_inc)
		else $error("push did not increment stack pointer");

	property p_sp_reset;
		@(posedge mclk) $rose(nrst) |-> stack_ptr_ff == `DMD_SP_RESET;
	endproperty
	a_sp_reset: assert property (p_sp_reset)
		else $error("stack pointer reset value wrong");

	property p_flash_wr;
		@(posedge mclk) disable iff (!nrst)
		flash_wr_ff |-> $past(program_store_control_ff[0]) && $past(movx_wr);
	endproperty
	a_flash_wr: assert property (p_flash_wr)
		else $error("flash write without enable");

	property p_movx_excl;
		@(posedge mclk) disable iff (!nrst) !(flash_wr_ff && xdata_wr_ff);
	endproperty
	a_movx_excl: assert property (p_movx_excl)
		else $error("movx write routed twice");

	property p_direct_sfr;
		@(posedge mclk) disable iff (!nrst)
		req.valid && !req.indirect && !req.bit_op && !req.reg_op &&
		req.addr[`DMD_UPPER_BIT] |-> is_sfr;
	endproperty
	a_direct_sfr: assert property (p_direct_sfr)
		else $error("direct upper access missed SPECIAL_FUNCTION_REGISTER space");

	property p_indirect_ram;
		@(posedge mclk) disable iff (!nrst)
		req.valid && req.indirect && !req.bit_op |-> !is_sfr;
	endproperty
	a_indirect_ram: assert property (p_indirect_ram)
		else $error("indirect access reached SPECIAL_FUNCTION_REGISTER space");

	property p_bank_range;
		@(posedge mclk) disable iff (!nrst)
		req.valid && req.reg_op && !req.bit_op |->
		eff_addr <= `DMD_BANK_LIMIT && eff_addr[4:3] == bank_ff;
	endproperty
	a_bank_range: assert property (p_bank_range)
		else $error("register operand outside active bank");

	property p_bit_ram;
		@(posedge mclk) disable iff (!nrst)
		req.valid && req.bit_op && !req.addr[`DMD_UPPER_BIT] |->
		eff_addr[7:4] == `DMD_BITRAM_BYTE && eff_addr[3:0] == req.addr[6:3];
	endproperty
	a_bit_ram: assert property (p_bit_ram)
		else $error("bit address mapped to wrong byte");

	property p_bit_sfr;
		@(posedge mclk) disable iff (!nrst)
		req.valid && req.bit_op && req.addr[`DMD_UPPER_BIT] |->
		is_sfr && eff_addr[2:0] == 3'h0;
	endproperty
	a_bit_sfr: assert property (p_bit_sfr)
		else $error("upper bit address not on x0/x8 SPECIAL_FUNCTION_REGISTER");

	property p_prog_4k;
		@(posedge mclk) disable iff (!nrst)
		!is_8k && paddr > `DMD_PROG_TOP_4K |=> !prog_ok_ff;
	endproperty
	a_prog_4k: assert property (p_prog_4k)
		else $error("4 kB variant backed above top");

	c_push: cover property (@(posedge mclk) disable iff (!nrst)
		req.valid && req.push ##1 req.valid && req.push);
	c_flash: cover property (@(posedge mclk) disable iff (!nrst)
		flash_wr_ff);
	c_bank3: cover property (@(posedge mclk) disable iff (!nrst)
		bank_ff == 2'h3 && req.valid && req.reg_op);
	c_bit: cover property (@(posedge mclk) disable iff (!nrst)
		req.valid && req.bit_op && rvalid_ff);
endmodule
`default_nettype wire

//--- src/dmd_cfg.svh
/*
 * Constants of the data-space decoder: addresses, reset values, fields.
 * Assumes inclusion by bare name from the package and design files.
 */
`ifndef DMD_CFG_SVH
`define DMD_CFG_SVH

// ----------------------------------------------------------------
// data space
// ----------------------------------------------------------------
`define DMD_UPPER_BIT 7
`define DMD_BANK_LIMIT 8'h1F
`define DMD_BITRAM_BASE 8'h20
`define DMD_BITRAM_BYTE 4'h2
`define DMD_RAM_DEPTH 256

// ----------------------------------------------------------------
// special function registers
// ----------------------------------------------------------------
`define DMD_SFR_SP 8'h81
`define DMD_SFR_PSW 8'hD0
`define DMD_SFR_PROGRAM_STORE_CONTROL 8'h8F
`define DMD_SP_RESET 8'h07
`define DMD_PSW_RESET 8'h00
`define DMD_PROGRAM_STORE_CONTROL_RESET 8'h00
`define DMD_RS_LO 3
`define DMD_RS_HI 4
`define DMD_PSWE_BIT 0

// ----------------------------------------------------------------
// program space
// ----------------------------------------------------------------
`define DMD_PROG_TOP_8K 16'h1FFF
`define DMD_PROG_RSVD_8K 16'h1DFF
`define DMD_PROG_TOP_4K 16'h0FFF

`endif

//--- src/dmd_pkg.sv
/*
 * Types of the data-space decoder.
 * Assumes dmd_cfg.svh is on the include path.
 */
`include "dmd_cfg.svh"

package dmd_pkg;
	// decoded target of a data access
	typedef enum logic [1:0] {DMD_T_RAM, DMD_T_SFR, DMD_T_NONE} dmd_target_t;

	// one data-space request from the core
	typedef struct packed {
		logic valid;
		logic wr;
		logic indirect;
		logic bit_op;
		logic reg_op;
		logic [2:0] reg_num;
		logic [7:0] addr;
		logic [7:0] wdata;
		logic push;
	} dmd_req_t;
endpackage

//--- src/dmd_prog_map.sv
/*
 * Program-space address map for the flash variants.
 * Assumes a registered address from the core; combinational check.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dmd_cfg.svh"

module dmd_prog_map
	import dmd_pkg::*;
(
	input wire logic [15:0] paddr, // program address
	input wire logic is_8k, // 8 kB variant selected
	output logic backed, // flash holds this address
	output logic reserved // reserved region of the map
);
	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	// only the part from zero upward is populated in the 64 kB space
	always_comb
	begin
		if (is_8k)
		begin
			backed = (paddr <= `DMD_PROG_TOP_8K);
			reserved = (paddr > `DMD_PROG_RSVD_8K);
		end
		else
		begin
			backed = (paddr <= `DMD_PROG_TOP_4K);
			reserved = (paddr > `DMD_PROG_TOP_4K);
		end
	end
endmodule

`default_nettype wire

//--- test/dmd_core_model.sv
/*
 * Core-side partner: issues data-space requests, movx writes and
 * program addresses to the decoder. Assumes dmd_pkg is compiled first
 * and that the decoder shares the single system clock.
 */
`timescale 1ns/1ps
`default_nettype none

module dmd_core_model
	import dmd_pkg::*;
(
	input wire logic mclk, // system clock
	output dmd_req_t req, // request to the decoder
	output logic movx_wr, // movx write strobe
	output logic [15:0] paddr, // program or movx address
	output logic is_8k // variant strap
);
	// idle values from time zero
	initial
	begin
		req = '0;
		movx_wr = 1'b0;
		paddr = 16'h0000;
		is_8k = 1'b1;
	end

	// one request, held up to the taking edge, then released
	// released fields are inverted so stale data cannot pass for valid
	// unoccupied SFR addresses are requested too, as 0x90 in the bench
	task automatic op(input logic [4:0] k, input logic [2:0] rn,
		input logic [7:0] a, input logic [7:0] d);
		dmd_req_t r;
		r = '{1'b1, k[3], k[2], k[1], k[0], rn, a, d, k[4]};
		@(posedge mclk);
		req <= r;
		@(posedge mclk);
		r = ~r;
		r.valid = 1'b0;
		req <= r;
		#1;
	endtask

	// one movx write strobe
	task automatic movx(input logic [15:0] a);
		@(posedge mclk);
		movx_wr <= 1'b1;
		paddr <= a;
		@(posedge mclk);
		movx_wr <= 1'b0;
		#1;
	endtask

	// present a program address and strap, wait one edge; both stay applied until the next call
	task automatic prog(input logic v, input logic [15:0] a);
		@(posedge mclk);
		is_8k <= v;
		paddr <= a;
		@(posedge mclk);
		#1;
	endtask
endmodule

`default_nettype wire

//--- test/tb_top.sv
/*
 * Self-checking bench of the data-space decoder.
 * Assumes dmd_cfg.svh on the include path and the core partner model.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dmd_cfg.svh"

module tb_top
	import dmd_pkg::*;
;
	// request kinds {push, wr, indirect, bit, reg}
	localparam logic [4:0] RD = 5'h00, WR = 5'h08, IRD = 5'h04;
	localparam logic [4:0] IWR = 5'h0C, BRD = 5'h02, BWR = 5'h0A;
	localparam logic [4:0] RWR = 5'h09, PSH = 5'h10;
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	dmd_req_t req;
	logic movx_wr, is_8k;
	logic [15:0] paddr;
	logic [7:0] rdata_ff, stack_ptr_ff;
	logic [1:0] bank_ff;
	logic rvalid_ff, sfr_ext_ff, flash_wr_ff, xdata_wr_ff, prog_ok_ff;
	int err_total = 0;
	int n_checks = 0;

	// ----------------------------------------------------------------
	// clock, instances
	// ----------------------------------------------------------------
	always #10 mclk = ~mclk;

	dmd_core_model i_dmd_core_model (.mclk(mclk), .req(req),
		.movx_wr(movx_wr), .paddr(paddr), .is_8k(is_8k));

	dmd_top i_dmd_top (.mclk(mclk), .nrst(nrst), .req(req),
		.movx_wr(movx_wr), .paddr(paddr), .is_8k(is_8k),
		.rdata_ff(rdata_ff), .rvalid_ff(rvalid_ff), .bank_ff(bank_ff),
		.stack_ptr_ff(stack_ptr_ff), .sfr_ext_ff(sfr_ext_ff),
		.flash_wr_ff(flash_wr_ff), .xdata_wr_ff(xdata_wr_ff),
		.prog_ok_ff(prog_ok_ff));

	// ----------------------------------------------------------------
	// shared helpers
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		n_checks++;
		if (g !== e)
		begin
			$display("wrong value %s expected %h seen %h", nm, e, g);
			err_total++;
		end
	endtask

	// read one byte or bit and judge the answer of the next edge
	task automatic rd(input logic [4:0] k, input logic [2:0] rn,
		input logic [7:0] a, input logic [7:0] e);
		i_dmd_core_model.op(k, rn, a, 8'h00);
		chk("rvalid", 16'h0001, {15'h0000, rvalid_ff});
		chk("rdata", {8'h00, e}, {8'h00, rdata_ff});
	endtask

	// bank follows the status register combinationally; one more edge is waited anyway
	task automatic bank(input logic [7:0] program_status_word, input logic [1:0] e);
		i_dmd_core_model.op(WR, 3'h0, `DMD_SFR_PSW, program_status_word);
		@(posedge mclk);
		#1;
		chk("bank", {14'h0000, e}, {14'h0000, bank_ff});
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_stack();
		chk("sp reset", 16'h0007, {8'h00, stack_ptr_ff});
		rd(RD, 3'h0, `DMD_SFR_SP, `DMD_SP_RESET);
		i_dmd_core_model.op(PSH, 3'h0, 8'h00, 8'h3C);
		chk("sp push", 16'h0008, {8'h00, stack_ptr_ff});
		rd(RD, 3'h0, 8'h08, 8'h3C);
		// stack moved off the banks before one more push
		i_dmd_core_model.op(WR, 3'h0, `DMD_SFR_SP, 8'hFE);
		i_dmd_core_model.op(PSH, 3'h0, 8'h00, 8'h77);
		chk("sp top", 16'h00FF, {8'h00, stack_ptr_ff});
		i_dmd_core_model.op(RWR, 3'h0, 8'h00, 8'hFF);
		rd(IRD, 3'h0, 8'h00, 8'h77);
	endtask

	task automatic t_banks();
		for (int b = 0; b < 4; b++)
		begin
			bank({3'h0, b[1:0], 3'h0}, b[1:0]);
			i_dmd_core_model.op(RWR, 3'h2, 8'h00, 8'hB0 + b[7:0]);
			rd(RD, 3'h0, 8'h02 + 8'(b * 8), 8'hB0 + b[7:0]);
		end
		i_dmd_core_model.op(RWR, 3'h1, 8'h00, 8'h40);
		i_dmd_core_model.op(IWR, 3'h1, 8'h00, 8'h66);
		rd(RD, 3'h0, 8'h40, 8'h66);
		i_dmd_core_model.op(RWR, 3'h0, 8'h00, 8'h90);
		i_dmd_core_model.op(IWR, 3'h0, 8'h00, 8'h5A);
		rd(IRD, 3'h0, 8'h00, 8'h5A);
		rd(RD, 3'h0, 8'h90, 8'h00);
		chk("sfr ext", 16'h0001, {15'h0000, sfr_ext_ff});
		rd(RD, 3'h0, 8'h1A, 8'hB3);
		bank(8'h00, 2'h0);
	endtask

	task automatic t_bits();
		i_dmd_core_model.op(WR, 3'h0, 8'h22, 8'h08);
		i_dmd_core_model.op(WR, 3'h0, 8'h13, 8'hA5);
		rd(BRD, 3'h0, 8'h13, 8'h01);
		rd(BRD, 3'h0, 8'h12, 8'h00);
		rd(RD, 3'h0, 8'h13, 8'hA5);
		i_dmd_core_model.op(BWR, 3'h0, 8'hD4, 8'h01);
		@(posedge mclk);
		#1;
		chk("bit bank", 16'h0002, {14'h0000, bank_ff});
		rd(BRD, 3'h0, 8'hD4, 8'h01);
		bank(8'h00, 2'h0);
	endtask

	task automatic t_movx();
		i_dmd_core_model.op(WR, 3'h0, `DMD_SFR_PROGRAM_STORE_CONTROL, 8'h01);
		i_dmd_core_model.movx(16'h0100);
		chk("flash wr", 16'h0001, {15'h0000, flash_wr_ff});
		chk("xdata wr", 16'h0000, {15'h0000, xdata_wr_ff});
		i_dmd_core_model.op(WR, 3'h0, `DMD_SFR_PROGRAM_STORE_CONTROL, 8'h00);
		i_dmd_core_model.movx(16'h0100);
		chk("flash off", 16'h0000, {15'h0000, flash_wr_ff});
		chk("xdata on", 16'h0001, {15'h0000, xdata_wr_ff});
	endtask

	task automatic t_prog();
		logic [16:0] tbl [6] = '{{1'b1, 16'h1DFF}, {1'b1, 16'h1E00},
			{1'b1, 16'h1FFF}, {1'b0, 16'h0FFF}, {1'b0, 16'h1000},
			{1'b1, 16'hFFFF}};
		logic exp [6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
		for (int i = 0; i < 6; i++)
		begin
			i_dmd_core_model.prog(tbl[i][16], tbl[i][15:0]);
			chk("prog ok", {15'h0, exp[i]}, {15'h0, prog_ok_ff});
		end
		i_dmd_core_model.prog(1'b0, 16'h0000);
		chk("prog zero", 16'h0001, {15'h0000, prog_ok_ff});
	endtask

	// a second reset mid-run must bring pointer and bank back
	task automatic t_reset();
		i_dmd_core_model.op(WR, 3'h0, `DMD_SFR_PSW, 8'h18);
		chk("bank pre", 16'h0003, {14'h0000, bank_ff});
		@(posedge mclk);
		nrst <= 1'b0;
		repeat (3) @(posedge mclk);
		nrst <= 1'b1;
		#1;
		chk("sp rst", 16'h0007, {8'h00, stack_ptr_ff});
		chk("bank rst", 16'h0000, {14'h0000, bank_ff});
		i_dmd_core_model.op(PSH, 3'h0, 8'h00, 8'hC3);
		rd(RD, 3'h0, 8'h08, 8'hC3);
	endtask

	// ----------------------------------------------------------------
	// main sequence and hang guard
	// ----------------------------------------------------------------
	initial
	begin
		repeat (3) @(posedge mclk);
		nrst <= 1'b1;
		#1;
		t_stack();
		t_banks();
		t_bits();
		t_movx();
		t_prog();
		t_reset();
		final_report();
	end

	// a stuck run is cut short and counted
	initial
	begin
		repeat (5000) @(posedge mclk);
		err_total++;
		final_report();
	end
endmodule

`default_nettype wire
